/* hw/lfi_consts.vh */
// Register map, field positions and timing constants for the fault-inject and Phy_register_access block
`ifndef LFI_CONSTS_VH
`define LFI_CONSTS_VH

// ----------------------------------------------------------------
// Bus and register map
// ----------------------------------------------------------------
`define LFI_ADDR_W 8
`define LFI_DATA_W 32
`define LFI_OFS_MAINT 8'h1c
`define LFI_OFS_PHY 8'h24
`define LFI_RST_MAINT 32'h0000_0000
`define LFI_RST_PHY 32'h0000_0000
`define LFI_RD_ZERO 32'h0000_0000

// ----------------------------------------------------------------
// Maintenance control fields (bit 00 is the word msb)
// ----------------------------------------------------------------
`define LFI_M_HCRC 31
`define LFI_M_DCRC 30
`define LFI_M_DROP 29
`define LFI_M_FACK 28
`define LFI_M_NOACK 27
`define LFI_M_ACK_HI 23
`define LFI_M_ACK_LO 16
`define LFI_M_PING_HI 8
`define LFI_M_PING_LO 0
`define LFI_ACK_W 8
`define LFI_PING_W 9

// ----------------------------------------------------------------
// Phy_register_access fields (bit 00 is the word msb)
// ----------------------------------------------------------------
`define LFI_P_RD 31
`define LFI_P_WR 30
`define LFI_P_IDX_HI 27
`define LFI_P_IDX_LO 24
`define LFI_P_WVAL_HI 23
`define LFI_P_WVAL_LO 16
`define LFI_P_RIDX_HI 11
`define LFI_P_RIDX_LO 8
`define LFI_P_RVAL_HI 7
`define LFI_P_RVAL_LO 0
`define LFI_IDX_W 4
`define LFI_VAL_W 8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LFI_CLK_PERIOD_NS 40
`define LFI_PING_STEP_NS 40
`define LFI_PING_STEP_CYC (`LFI_PING_STEP_NS / `LFI_CLK_PERIOD_NS)

`endif

/* hw/lfi_ping_timer.v */
// Ping response timer: counts from ping sent to response seen
`timescale 1ns/1ns
`include "lfi_consts.vh"

module lfi_ping_timer #(
  parameter W = `LFI_PING_W,
  parameter PW = 8,
  parameter [PW-1:0] STEP_CYC = `LFI_PING_STEP_CYC
) (
  input wire clock_i,
  input wire nrst_i,
  input wire start_i,
  input wire stop_i,
  output wire [W-1:0] result_o
);

  reg running_q;
  reg [PW-1:0] pre_q;
  reg [W-1:0] cnt_q;
  reg [W-1:0] result_q;
  wire step_w;
  wire sat_w;

  assign step_w = (pre_q == STEP_CYC - {{(PW-1){1'b0}}, 1'b1});
  assign sat_w = &cnt_q;
  assign result_o = result_q;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Saturates so a very late reply reads as full scale, not a wrap
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      running_q <= 1'b0;
      pre_q <= {PW{1'b0}};
      cnt_q <= {W{1'b0}};
      result_q <= {W{1'b0}};
    end else if (start_i) begin
      running_q <= 1'b1;
      pre_q <= {PW{1'b0}};
      cnt_q <= {W{1'b0}};
    end else if (running_q) begin
      if (stop_i) begin
        running_q <= 1'b0;
        result_q <= cnt_q; // R8
      end else if (step_w) begin
        pre_q <= {PW{1'b0}};
        if (!sat_w) begin
          cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1}; // R8
        end
      end else begin
        pre_q <= pre_q + {{(PW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // lfi_ping_timer

/* hw/lfi_top.v */
// Link fault injection and PHY register access block
// What this block does
// R1: All register bits clear at power-up
// R2: Header CRC fault on next primary packet
// R3: Data CRC fault, clear once sent
// R4: Drop next primary packet, then clear
// R5: Override next acknowledge with stored code
// R6: Suppress next acknowledge, then clear
// R7: Hold writable eight-bit acknowledge value
// R8: Report ping response time, 40 ns steps
// R9: Read request to PHY, clear when sent
// R10: Write request to PHY, clear when sent
// R11: Software sets PHY index before requesting
// R12: Software loads write byte before writing
// R13: Hold last PHY reply index and value
// R14: Latch reply index and value together
// R15: Read before write, one at a time
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ns
`include "lfi_consts.vh"

module lfi_top #(
  parameter AW = `LFI_ADDR_W,
  parameter DW = `LFI_DATA_W
) (
  input wire clock_i,
  input wire nrst_i,
  // Register port
  input wire [AW-1:0] reg_addr_i,
  input wire [DW-1:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output wire [DW-1:0] reg_rdata_o,
  // Transmitter side
  input wire pkt_hdr_done_i,
  input wire pkt_dcrc_sent_i,
  input wire pkt_dropped_i,
  input wire ack_gen_i,
  input wire ack_dropped_i,
  output wire inject_header_crc_error_o,
  output wire inject_data_crc_error_o,
  output wire drop_next_packet_o,
  output wire ack_override_o,
  output wire [`LFI_ACK_W-1:0] ack_value_o,
  output wire ack_suppress_o,
  // Ping timing
  input wire ping_sent_i,
  input wire ping_reply_i,
  // PHY register requests
  output wire phy_req_valid_o,
  output wire phy_req_write_o,
  output wire [`LFI_IDX_W-1:0] phy_req_index_o,
  output wire [`LFI_VAL_W-1:0] phy_req_value_o,
  input wire phy_req_sent_i,
  // PHY register replies
  input wire phy_reply_valid_i,
  input wire [`LFI_IDX_W-1:0] phy_reply_index_i,
  input wire [`LFI_VAL_W-1:0] phy_reply_value_i
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_READ = 2'h1;
  localparam [1:0] ST_WRITE = 2'h2;
  // Reset words; each field except the ping count (reset inside lfi_ping_timer) takes its reset value from these
  localparam [DW-1:0] RST_MAINT = `LFI_RST_MAINT;
  localparam [DW-1:0] RST_PHY = `LFI_RST_PHY;

  reg hcrc_q;
  reg hcrc_d;
  reg dcrc_q;
  reg dcrc_d;
  reg drop_q;
  reg drop_d;
  reg fack_q;
  reg fack_d;
  reg noack_q;
  reg noack_d;
  reg [`LFI_ACK_W-1:0] ack_val_q;
  reg phy_rd_q;
  reg phy_rd_d;
  reg phy_wr_q;
  reg phy_wr_d;
  reg [`LFI_IDX_W-1:0] phy_idx_q;
  reg [`LFI_VAL_W-1:0] phy_wval_q;
  reg [`LFI_IDX_W-1:0] rep_idx_q;
  reg [`LFI_VAL_W-1:0] rep_val_q;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg req_valid_q;
  reg req_valid_d;
  reg req_write_q;
  reg req_write_d;
  reg [`LFI_IDX_W-1:0] req_idx_q;
  reg [`LFI_IDX_W-1:0] req_idx_d;
  reg [`LFI_VAL_W-1:0] req_val_q;
  reg [`LFI_VAL_W-1:0] req_val_d;
  reg [DW-1:0] rdata_q;
  reg [DW-1:0] rdata_d;
  reg [DW-1:0] maint_w;
  reg [DW-1:0] phy_w;
  wire wr_maint_w;
  wire wr_phy_w;
  wire [`LFI_PING_W-1:0] ping_w;
  wire req_done_w;

  assign wr_maint_w = reg_wr_i && (reg_addr_i == `LFI_OFS_MAINT);
  assign wr_phy_w = reg_wr_i && (reg_addr_i == `LFI_OFS_PHY);
  assign req_done_w = req_valid_q && phy_req_sent_i;

  // ----------------------------------------------------------------
  // Ping timer
  // ----------------------------------------------------------------
  // Ping field is read-only; a write to it is dropped
  lfi_ping_timer #(
    .W(`LFI_PING_W)
  ) u_ping (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .start_i(ping_sent_i),
    .stop_i(ping_reply_i),
    .result_o(ping_w)
  );

  // ----------------------------------------------------------------
  // Fault inject flags
  // ----------------------------------------------------------------
  // A software write lands after the hardware clear, so a set made in
  // the same cycle as the consuming event is kept for the next packet
  always @* begin
    hcrc_d = hcrc_q;
    dcrc_d = dcrc_q;
    drop_d = drop_q;
    fack_d = fack_q;
    noack_d = noack_q;
    if (pkt_hdr_done_i) begin
      hcrc_d = 1'b0; // R2
    end
    if (pkt_dcrc_sent_i) begin
      dcrc_d = 1'b0; // R3
    end
    if (pkt_dropped_i) begin
      drop_d = 1'b0; // R4
    end
    if (ack_gen_i) begin
      fack_d = 1'b0; // R5
    end
    if (ack_dropped_i) begin
      noack_d = 1'b0; // R6
    end
    if (wr_maint_w) begin
      hcrc_d = reg_wdata_i[`LFI_M_HCRC];
      dcrc_d = reg_wdata_i[`LFI_M_DCRC];
      drop_d = reg_wdata_i[`LFI_M_DROP];
      fack_d = reg_wdata_i[`LFI_M_FACK];
      noack_d = reg_wdata_i[`LFI_M_NOACK];
    end
  end

  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hcrc_q <= RST_MAINT[`LFI_M_HCRC]; // R1
      dcrc_q <= RST_MAINT[`LFI_M_DCRC];
      drop_q <= RST_MAINT[`LFI_M_DROP];
      fack_q <= RST_MAINT[`LFI_M_FACK];
      noack_q <= RST_MAINT[`LFI_M_NOACK];
      ack_val_q <= RST_MAINT[`LFI_M_ACK_HI:`LFI_M_ACK_LO];
    end else begin
      hcrc_q <= hcrc_d;
      dcrc_q <= dcrc_d;
      drop_q <= drop_d;
      fack_q <= fack_d;
      noack_q <= noack_d;
      if (wr_maint_w) begin
        ack_val_q <= reg_wdata_i[`LFI_M_ACK_HI:`LFI_M_ACK_LO]; // R7
      end
    end
  end

  // ----------------------------------------------------------------
  // Flag outputs
  // ----------------------------------------------------------------
  assign inject_header_crc_error_o = hcrc_q; // R2
  assign inject_data_crc_error_o = dcrc_q; // R3
  assign drop_next_packet_o = drop_q; // R4
  assign ack_override_o = fack_q; // R5
  assign ack_value_o = ack_val_q; // R7
  assign ack_suppress_o = noack_q; // R6

  // ----------------------------------------------------------------
  // Phy_register_access register and reply capture
  // ----------------------------------------------------------------
  always @* begin
    phy_rd_d = phy_rd_q;
    phy_wr_d = phy_wr_q;
    if (req_done_w && !req_write_q) begin
      phy_rd_d = 1'b0; // R9
    end
    if (req_done_w && req_write_q) begin
      phy_wr_d = 1'b0; // R10
    end
    if (wr_phy_w) begin
      phy_rd_d = reg_wdata_i[`LFI_P_RD];
      phy_wr_d = reg_wdata_i[`LFI_P_WR];
    end
  end

  // A reply beats a software write to the reply fields so data from
  // the PHY is never lost
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phy_rd_q <= RST_PHY[`LFI_P_RD]; // R1
      phy_wr_q <= RST_PHY[`LFI_P_WR];
      phy_idx_q <= RST_PHY[`LFI_P_IDX_HI:`LFI_P_IDX_LO];
      phy_wval_q <= RST_PHY[`LFI_P_WVAL_HI:`LFI_P_WVAL_LO];
      rep_idx_q <= RST_PHY[`LFI_P_RIDX_HI:`LFI_P_RIDX_LO];
      rep_val_q <= RST_PHY[`LFI_P_RVAL_HI:`LFI_P_RVAL_LO];
    end else begin
      phy_rd_q <= phy_rd_d;
      phy_wr_q <= phy_wr_d;
      if (wr_phy_w) begin
        phy_idx_q <= reg_wdata_i[`LFI_P_IDX_HI:`LFI_P_IDX_LO]; // R11
        phy_wval_q <= reg_wdata_i[`LFI_P_WVAL_HI:`LFI_P_WVAL_LO]; // R12
      end
      if (phy_reply_valid_i) begin
        rep_idx_q <= phy_reply_index_i; // R14
        rep_val_q <= phy_reply_value_i; // R14
      end else if (wr_phy_w) begin
        rep_idx_q <= reg_wdata_i[`LFI_P_RIDX_HI:`LFI_P_RIDX_LO]; // R13
        rep_val_q <= reg_wdata_i[`LFI_P_RVAL_HI:`LFI_P_RVAL_LO]; // R13
      end
    end
  end

  // ----------------------------------------------------------------
  // PHY request sequencer
  // ----------------------------------------------------------------
  // Index and byte are frozen at launch; later writes do not disturb
  // a request that is already out
  // Clearing a request bit cancels only a launch not yet made
  always @* begin
    state_d = state_q;
    req_valid_d = req_valid_q;
    req_write_d = req_write_q;
    req_idx_d = req_idx_q;
    req_val_d = req_val_q;
    case (state_q)
      ST_IDLE: begin
        if (phy_rd_q) begin
          state_d = ST_READ; // R15
          req_valid_d = 1'b1; // R9
          req_write_d = 1'b0;
          req_idx_d = phy_idx_q;
          req_val_d = {`LFI_VAL_W{1'b0}};
        end else if (phy_wr_q) begin
          state_d = ST_WRITE; // R15
          req_valid_d = 1'b1; // R10
          req_write_d = 1'b1;
          req_idx_d = phy_idx_q;
          req_val_d = phy_wval_q;
        end
      end
      // Sent counts only while a request is out, never in idle
      ST_READ, ST_WRITE: begin
        if (phy_req_sent_i) begin
          state_d = ST_IDLE; // R15
          req_valid_d = 1'b0;
        end
      end
      default: begin
        state_d = ST_IDLE;
        req_valid_d = 1'b0;
      end
    endcase
  end

  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
      req_valid_q <= 1'b0;
      req_write_q <= 1'b0;
      req_idx_q <= {`LFI_IDX_W{1'b0}};
      req_val_q <= {`LFI_VAL_W{1'b0}};
    end else begin
      state_q <= state_d;
      req_valid_q <= req_valid_d;
      req_write_q <= req_write_d;
      req_idx_q <= req_idx_d;
      req_val_q <= req_val_d;
    end
  end

  assign phy_req_valid_o = req_valid_q;
  assign phy_req_write_o = req_write_q;
  assign phy_req_index_o = req_idx_q;
  assign phy_req_value_o = req_val_q;

  // ----------------------------------------------------------------
  // Register read path
  // ----------------------------------------------------------------
  always @* begin
    // Reserved bits read as zero
    maint_w = `LFI_RD_ZERO;
    maint_w[`LFI_M_HCRC] = hcrc_q;
    maint_w[`LFI_M_DCRC] = dcrc_q;
    maint_w[`LFI_M_DROP] = drop_q;
    maint_w[`LFI_M_FACK] = fack_q;
    maint_w[`LFI_M_NOACK] = noack_q;
    maint_w[`LFI_M_ACK_HI:`LFI_M_ACK_LO] = ack_val_q;
    maint_w[`LFI_M_PING_HI:`LFI_M_PING_LO] = ping_w; // R8
    phy_w = `LFI_RD_ZERO;
    phy_w[`LFI_P_RD] = phy_rd_q;
    phy_w[`LFI_P_WR] = phy_wr_q;
    phy_w[`LFI_P_IDX_HI:`LFI_P_IDX_LO] = phy_idx_q;
    phy_w[`LFI_P_WVAL_HI:`LFI_P_WVAL_LO] = phy_wval_q;
    phy_w[`LFI_P_RIDX_HI:`LFI_P_RIDX_LO] = rep_idx_q; // R13
    phy_w[`LFI_P_RVAL_HI:`LFI_P_RVAL_LO] = rep_val_q; // R13
  end

  // Data stand only in the cycle after the strobe; zero otherwise
  always @* begin
    rdata_d = `LFI_RD_ZERO;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `LFI_OFS_MAINT: rdata_d = maint_w;
        `LFI_OFS_PHY: rdata_d = phy_w;
        default: rdata_d = `LFI_RD_ZERO;
      endcase
    end
  end

  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= `LFI_RD_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

endmodule // lfi_top

/* tb/lfi_top_properties.sv */
// Concurrent checks on the fault-inject and Phy_register_access block ports
`timescale 1ns/1ns
module lfi_top_chk (
  input logic clock_i,
  input logic nrst_i,
  input logic [7:0] reg_addr_i,
  input logic [31:0] reg_wdata_i,
  input logic reg_wr_i,
  input logic reg_rd_i,
  input logic [31:0] reg_rdata_o,
  input logic pkt_hdr_done_i,
  input logic pkt_dcrc_sent_i,
  input logic pkt_dropped_i,
  input logic ack_gen_i,
  input logic ack_dropped_i,
  input logic inject_header_crc_error_o,
  input logic inject_data_crc_error_o,
  input logic drop_next_packet_o,
  input logic ack_override_o,
  input logic [7:0] ack_value_o,
  input logic ack_suppress_o,
  input logic phy_req_valid_o,
  input logic phy_req_write_o,
  input logic [3:0] phy_req_index_o,
  input logic phy_req_sent_i
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // ----------------------------------------
  // Fault flags, excluding same-cycle writes
  // ----------------------------------------
  a_hcrc_clear: assert property (pkt_hdr_done_i && !reg_wr_i |=> !inject_header_crc_error_o)
    else $error("header crc flag kept");
  a_dcrc_clear: assert property (pkt_dcrc_sent_i && !reg_wr_i |=> !inject_data_crc_error_o)
    else $error("data crc flag kept");
  a_drop_clear: assert property (pkt_dropped_i && !reg_wr_i |=> !drop_next_packet_o)
    else $error("drop flag kept");
  a_override_clear: assert property (ack_gen_i && !reg_wr_i |=> !ack_override_o)
    else $error("override flag kept");
  a_suppress_clear: assert property (ack_dropped_i && !reg_wr_i |=> !ack_suppress_o)
    else $error("suppress flag kept");
  a_ack_value: assert property (reg_wr_i && reg_addr_i == 8'h1c |=>
    ack_value_o == $past(reg_wdata_i[23:16])) else $error("ack value not stored");
  // ----------------------------------------
  // PHY requests and read port
  // ----------------------------------------
  a_req_hold: assert property (phy_req_valid_o && !phy_req_sent_i |=>
    phy_req_valid_o && $stable(phy_req_index_o) && $stable(phy_req_write_o))
    else $error("request dropped early");
  a_req_release: assert property (phy_req_valid_o && phy_req_sent_i |=> !phy_req_valid_o)
    else $error("request kept after send");
  a_read_launch: assert property (reg_wr_i && reg_addr_i == 8'h24 && reg_wdata_i[31] &&
    !phy_req_valid_o && !$past(phy_req_valid_o) && !$past(reg_wr_i) |=> ##1
    phy_req_valid_o && !phy_req_write_o &&
    phy_req_index_o == $past(reg_wdata_i[27:24], 2)) else $error("read request not launched");
  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data outside read slot");
endmodule // lfi_top_chk

bind lfi_top lfi_top_chk i_chk (.*);

/* tb/lfi_phy_model.sv */
// Behavioural PHY: takes requests, answers reads with a reply
`timescale 1ns/1ns
module lfi_phy_model (
  input logic clock_i,
  input logic nrst_i,
  input logic slow_i,
  input logic req_valid_i,
  input logic req_write_i,
  input logic [3:0] req_index_i,
  output logic sent_o,
  output logic reply_valid_o,
  output logic [3:0] reply_index_o,
  output logic [7:0] reply_value_o
);
  logic [2:0] cnt_q;
  logic [3:0] idx_q;
  logic [1:0] rep_q;
  logic rd_q;
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {sent_o, reply_valid_o, cnt_q, idx_q, rep_q, rd_q} <= '0;
      {reply_index_o, reply_value_o} <= 12'ha5c;
    end else begin
      sent_o <= 1'b0;
      reply_valid_o <= 1'b0;
      rep_q <= {rep_q[0], sent_o & rd_q};
      // Stale reply lines flip so a late sample cannot pass
      if (reply_valid_o) begin
        reply_index_o <= ~reply_index_o;
        reply_value_o <= ~reply_value_o;
      end
      if (req_valid_i && !sent_o) begin
        cnt_q <= cnt_q + 3'd1;
        if (cnt_q == (slow_i ? 3'd4 : 3'd0)) begin
          sent_o <= 1'b1;
          cnt_q <= 3'd0;
          idx_q <= req_index_i;
          rd_q <= !req_write_i;
        end
      end
      if (rep_q[1]) begin
        reply_valid_o <= 1'b1;
        reply_index_o <= idx_q;
        reply_value_o <= {~idx_q, idx_q};
      end
    end
  end
endmodule // lfi_phy_model

/* tb/lfi_top_test.sv */
// Self-checking bench for the fault-inject and Phy_register_access block
`timescale 1ns/1ns
module lfi_top_test;
  logic clock_i = 0, nrst_i = 0, wr = 0, rd = 0, slow = 0, ps = 0, pr = 0;
  logic [7:0] addr = 0;
  logic [31:0] wdata = 0, rdv;
  logic [4:0] cons = 0;
  logic [7:0] log_q = 0;
  logic [3:0] idx;
  wire [4:0] flg;
  wire [31:0] rdata;
  wire vld, wrt, sent, rv;
  wire [3:0] ridx, qidx;
  wire [7:0] rval, qval, ackv;
  int error_cnt = 0, n_compared = 0;

  lfi_top i_dut (.clock_i(clock_i), .nrst_i(nrst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .pkt_hdr_done_i(cons[0]),
    .pkt_dcrc_sent_i(cons[1]), .pkt_dropped_i(cons[2]), .ack_gen_i(cons[3]),
    .ack_dropped_i(cons[4]), .inject_header_crc_error_o(flg[0]),
    .inject_data_crc_error_o(flg[1]), .drop_next_packet_o(flg[2]), .ack_override_o(flg[3]),
    .ack_value_o(ackv), .ack_suppress_o(flg[4]), .ping_sent_i(ps), .ping_reply_i(pr),
    .phy_req_valid_o(vld), .phy_req_write_o(wrt), .phy_req_index_o(qidx),
    .phy_req_value_o(qval), .phy_req_sent_i(sent), .phy_reply_valid_i(rv),
    .phy_reply_index_i(ridx), .phy_reply_value_i(rval));

  lfi_phy_model i_phy (.clock_i(clock_i), .nrst_i(nrst_i), .slow_i(slow), .req_valid_i(vld),
    .req_write_i(wrt), .req_index_i(qidx), .sent_o(sent), .reply_valid_o(rv),
    .reply_index_o(ridx), .reply_value_o(rval));

  initial forever #20 clock_i = ~clock_i;

  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_i);
    addr <= a; rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Order of requests seen by the PHY, two bits each so a lost one shows
  always @(posedge clock_i) begin
    if (vld && sent) begin
      log_q <= {log_q[5:0], 1'b1, wrt};
      if (wrt) check({24'h0, qval}, 32'h3c);
    end
  end

  initial begin
    #100000;
    error_cnt++;
    conclude();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clock_i);
    nrst_i <= 1'b1;
    rreg(8'h1c, rdv); check(rdv, 32'h0);
    rreg(8'h24, rdv); check(rdv, 32'h0);
    wreg(8'h20, 32'hffff_ffff);
    rreg(8'h20, rdv); check(rdv, 32'h0);
    for (int k = 0; k < 5; k++) begin
      wreg(8'h1c, (32'h8000_0000 >> k) | 32'h00a5_0000);
      @(posedge clock_i);
      #1 check({27'h0, flg}, {27'h0, 5'h1 << k});
      check({24'h0, ackv}, 32'ha5);
      @(posedge clock_i); cons <= 5'h1 << k;
      @(posedge clock_i); cons <= 5'h0;
      rreg(8'h1c, rdv); check(rdv, 32'h00a5_0000);
    end
    @(posedge clock_i); ps <= 1'b1;
    @(posedge clock_i); ps <= 1'b0;
    repeat (4) @(posedge clock_i);
    pr <= 1'b1;
    @(posedge clock_i); pr <= 1'b0;
    wreg(8'h1c, 32'h0000_01ff);
    rreg(8'h1c, rdv); check(rdv, 32'h0000_0004);
    for (int k = 0; k < 2; k++) begin
      slow <= k[0];
      idx = k[0] ? 4'hf : 4'h3;
      wreg(8'h24, {4'h8, idx, 24'h0});
      repeat (30) begin
        @(posedge clock_i);
        if (rv) break;
      end
      @(posedge clock_i);
      rreg(8'h24, rdv); check(rdv, {4'h0, idx, 12'h0, idx, ~idx, idx});
    end
    wreg(8'h24, 32'hc63c_0000);
    repeat (30) @(posedge clock_i);
    check({24'h0, log_q}, 32'hab);
    rreg(8'h24, rdv); check(rdv, 32'h063c_0696);
    conclude();
  end
endmodule // lfi_top_test
